// ===== logic/dcm_ctrl.sv
/*
  control side of an eight-channel dac: write-only register bank over 3-wire or i2c,
  soft-mute ramp, de-emphasis selection, clock-stop reset and power-up sequencing.
  assumes all pins are asynchronous to clk_sys_i and the host waits before writing.
*/
`default_nettype none
`include "dcm_params.svh"
module dcm_ctrl
  import dcm_pkg::*;
#(
  parameter int WRITE_HOLD_CYC = `DCM_WRITE_HOLD_CYC
)(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic serial_mode_i,
  input wire logic i2c_mode_i,
  input wire logic bus_address_select_pin_i,
  input wire logic chip_select_n_i,
  input wire logic control_serial_clock_i,
  input wire logic control_serial_in_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic master_clock_i,
  input wire logic word_clock_i,
  input wire logic bit_clock_i,
  input wire logic par_soft_silence_i,
  input wire logic [1:0] par_deemph_rate_select_i,
  output logic [2:0] serial_format_select_o,
  output logic [1:0] multichannel_frame_select_o,
  output logic slow_rolloff_o,
  output logic [3:0] channel_power_bits_o,
  output logic [1:0] speed_o,
  output logic [7:0] deemph_mode_o,
  output logic [12:0] atten_level_o,
  output logic in_reset_o,
  output logic analog_up_o,
  output logic digital_up_o,
  output logic output_valid_o
);
  // ==================================================================
  // elaboration checks
  if (WRITE_HOLD_CYC < 1 || WRITE_HOLD_CYC > 1048575)
  begin : g_chk
    $error("WRITE_HOLD_CYC out of range");
  end

  // ==================================================================
  // helpers
  function automatic dcm_regs_t apply_write(input dcm_regs_t r, input logic [4:0] a,
                                            input logic [7:0] d);
    dcm_regs_t res;
    res = r;
    if (a == `DCM_ADDR_FSM && d[`DCM_BIT_REGISTER_INIT_BIT])
    begin
      res = {`DCM_RST_DEM, `DCM_RST_PWR, `DCM_RST_FSM, `DCM_RST_FMT};
    end
    else if (a <= `DCM_ADDR_LAST)
    begin
      res[a[1:0]] = d;
    end
    return res;
  endfunction

  dcm_state_t s_reg;
  dcm_state_t s_next;
  logic serial_on, i2c_on, trst, mute_req, wc_edge, bc_edge, mc_edge, tick;
  logic scl_rise, scl_fall, i2c_start, i2c_stop, wc_stop, bc_stop, mc_stop, clocks_ok;
  logic cs_rise, control_serial_clock_rise, i2c_store;
  logic [12:0] step;
  logic [9:0] cp_len;
  logic [1:0] dem_rate;
  dcm_speed_t spd_sel;

  assign serial_on = s_reg.ser_s[1];
  assign i2c_on = serial_on && s_reg.i2c_s[1];
  // parallel mode has no timing-reset pin, so timing runs freely there
  assign trst = serial_on ? s_reg.regs[0][`DCM_BIT_TRST] : 1'b1;
  assign mute_req = serial_on ? s_reg.regs[1][`DCM_BIT_MUTE] : s_reg.par2[2];
  assign dem_rate = serial_on ? s_reg.regs[1][`DCM_LSB_DEMR +: 2] : s_reg.par2[1:0];
  assign wc_edge = s_reg.wc_s[1] && !s_reg.wc_s[2];
  assign bc_edge = s_reg.bc_s[1] && !s_reg.bc_s[2];
  assign mc_edge = s_reg.mc_s[1] != s_reg.mc_s[2];
  assign tick = s_reg.tick_cnt >= s_reg.per_meas;
  assign wc_stop = s_reg.wc_idle > `DCM_STOP_SAMPLES;
  assign bc_stop = s_reg.bc_idle > `DCM_STOP_SAMPLES;
  assign mc_stop = s_reg.mc_idle >= `DCM_MCLK_STOP_CYC;
  assign clocks_ok = !wc_stop && !bc_stop && !mc_stop && trst;
  assign scl_rise = s_reg.scl_s[1] && !s_reg.scl_s[2];
  assign scl_fall = !s_reg.scl_s[1] && s_reg.scl_s[2];
  assign i2c_start = s_reg.scl_s[1] && s_reg.scl_s[2] && s_reg.sda_s[2] && !s_reg.sda_s[1];
  assign i2c_stop = s_reg.scl_s[1] && s_reg.scl_s[2] && !s_reg.sda_s[2] && s_reg.sda_s[1];
  assign cs_rise = s_reg.cs_s[1] && !s_reg.cs_s[2];
  assign control_serial_clock_rise = s_reg.ck_s[1] && !s_reg.ck_s[2];
  assign i2c_store = i2c_on && scl_fall && !s_reg.iack && s_reg.ibit == 4'h8
                     && s_reg.ist == I_DATA;

  // ==================================================================
  // speed selection
  always_comb
  begin
    if (!serial_on || s_reg.regs[0][`DCM_BIT_AUTO_CLOCK_DETECT])
    begin
      if (s_reg.per_meas >= `DCM_NORMAL_MIN_PER)
        spd_sel = SPD_NORMAL;
      else if (s_reg.per_meas >= `DCM_DOUBLE_MIN_PER)
        spd_sel = SPD_DOUBLE;
      else
        spd_sel = SPD_QUAD;
    end
    else
    begin
      case (s_reg.regs[1][`DCM_LSB_DFS +: 2])
        2'h1: spd_sel = SPD_DOUBLE;
        2'h2: spd_sel = SPD_QUAD;
        default: spd_sel = SPD_NORMAL;
      endcase
    end
    case (s_reg.speed)
      SPD_DOUBLE:
      begin
        step = 13'h0002;
        cp_len = `DCM_CP_DOUBLE;
      end
      SPD_QUAD:
      begin
        step = 13'h0001;
        cp_len = `DCM_CP_QUAD;
      end
      default:
      begin
        step = 13'h0004;
        cp_len = `DCM_CP_NORMAL;
      end
    endcase
  end

  // ==================================================================
  // next state
  always_comb
  begin
    s_next = s_reg;
    s_next.cs_s = {s_reg.cs_s[1:0], chip_select_n_i};
    s_next.ck_s = {s_reg.ck_s[1:0], control_serial_clock_i};
    s_next.di_s = {s_reg.di_s[1:0], control_serial_in_i};
    s_next.scl_s = {s_reg.scl_s[1:0], scl_i};
    s_next.sda_s = {s_reg.sda_s[1:0], sda_i};
    s_next.wc_s = {s_reg.wc_s[1:0], word_clock_i};
    s_next.bc_s = {s_reg.bc_s[1:0], bit_clock_i};
    s_next.mc_s = {s_reg.mc_s[1:0], master_clock_i};
    s_next.ser_s = {s_reg.ser_s[0], serial_mode_i};
    s_next.i2c_s = {s_reg.i2c_s[0], i2c_mode_i};
    s_next.sel_s = {s_reg.sel_s[0], bus_address_select_pin_i};
    s_next.par1 = {par_soft_silence_i, par_deemph_rate_select_i};
    s_next.par2 = s_reg.par1;
    s_next.speed = spd_sel;
    if (s_reg.hold_cnt >= 20'(WRITE_HOLD_CYC - 1))
      s_next.wr_ok = 1'b1;
    else
      s_next.hold_cnt = s_reg.hold_cnt + 20'h00001;

    // 3-wire port: only writes exist, nothing is ever shifted out
    if (!serial_on || i2c_on || s_reg.cs_s[1])
      s_next.n3 = 5'h00;
    else if (control_serial_clock_rise)
    begin
      s_next.sh3 = {s_reg.sh3[14:0], s_reg.di_s[1]};
      if (s_reg.n3 != 5'h1F)
        s_next.n3 = s_reg.n3 + 5'h01;
    end
    if (serial_on && !i2c_on && cs_rise && s_reg.wr_ok && s_reg.n3 == `DCM_3W_BITS
        && s_reg.sh3[15:13] == `DCM_3W_HEAD)
      s_next.regs = apply_write(s_reg.regs, s_reg.sh3[12:8], s_reg.sh3[7:0]);

    // i2c slave, write only; a read address gets no acknowledge
    if (!i2c_on || i2c_stop)
    begin
      s_next.ist = I_IDLE;
      s_next.sda_drv = 1'b0;
      s_next.iack = 1'b0;
    end
    else if (i2c_start)
    begin
      s_next.ist = I_DEV;
      s_next.ibit = 4'h0;
      s_next.iack = 1'b0;
      s_next.sda_drv = 1'b0;
    end
    else if (scl_rise && !s_reg.iack && s_reg.ist != I_IDLE && s_reg.ibit != 4'h8)
    begin
      s_next.ish = {s_reg.ish[6:0], s_reg.sda_s[1]};
      s_next.ibit = s_reg.ibit + 4'h1;
    end
    else if (scl_fall && s_reg.iack)
    begin
      s_next.sda_drv = 1'b0;
      s_next.iack = 1'b0;
      s_next.ibit = 4'h0;
    end
    else if (scl_fall && s_reg.ibit == 4'h8)
    begin
      s_next.ibit = 4'h0;
      case (s_reg.ist)
        I_DEV:
        begin
          if (s_reg.ish[7:1] == {`DCM_I2C_ADDR, s_reg.sel_s[1]} && !s_reg.ish[0]
              && s_reg.wr_ok)
          begin
            s_next.ist = I_REG;
            s_next.sda_drv = 1'b1;
            s_next.iack = 1'b1;
          end
          else
            s_next.ist = I_SKIP;
        end
        I_REG:
        begin
          s_next.ptr = s_reg.ish[4:0];
          s_next.ist = I_DATA;
          s_next.sda_drv = 1'b1;
          s_next.iack = 1'b1;
        end
        I_DATA:
        begin
          s_next.regs = apply_write(s_reg.regs, s_reg.ptr, s_reg.ish);
          s_next.ptr = (s_reg.ptr == `DCM_ADDR_LAST) ? 5'h00 : s_reg.ptr + 5'h01;
          s_next.sda_drv = 1'b1;
          s_next.iack = 1'b1;
        end
        default: s_next.ist = s_reg.ist;
      endcase
    end

    // clock supervision; word period is the unit of a sample period
    if (wc_edge)
    begin
      s_next.per_meas = s_reg.per_cnt;
      s_next.per_cnt = 13'h0000;
    end
    else if (s_reg.per_cnt != 13'h1FFF)
      s_next.per_cnt = s_reg.per_cnt + 13'h0001;
    s_next.tick_cnt = tick ? 13'h0000 : s_reg.tick_cnt + 13'h0001;
    if (wc_edge)
      s_next.wc_idle = 12'h000;
    else if (tick && !wc_stop)
      s_next.wc_idle = s_reg.wc_idle + 12'h001;
    if (bc_edge)
      s_next.bc_idle = 12'h000;
    else if (tick && !bc_stop)
      s_next.bc_idle = s_reg.bc_idle + 12'h001;
    if (mc_edge)
      s_next.mc_idle = 8'h00;
    else if (!mc_stop)
      s_next.mc_idle = s_reg.mc_idle + 8'h01;

    // power-up sequence
    if (!clocks_ok)
    begin
      s_next.pst = PW_RESET;
      s_next.pcnt = 10'h000;
    end
    else
    begin
      case (s_reg.pst)
        PW_RESET:
        begin
          s_next.pst = PW_ANALOG;
          s_next.pcnt = 10'h000;
        end
        PW_ANALOG:
        begin
          if (s_reg.pcnt >= 10'(`DCM_ANALOG_CYC - 1))
          begin
            s_next.pst = PW_DIGITAL;
            s_next.pcnt = 10'h000;
          end
          else
            s_next.pcnt = s_reg.pcnt + 10'h001;
        end
        PW_DIGITAL:
        begin
          if (wc_edge && s_reg.pcnt >= `DCM_DIG_WAIT_LR - 10'h001)
          begin
            s_next.pst = PW_PUMP;
            s_next.pcnt = 10'h000;
          end
          else if (wc_edge)
            s_next.pcnt = s_reg.pcnt + 10'h001;
        end
        PW_PUMP:
        begin
          if (wc_edge && s_reg.pcnt >= cp_len - 10'h001)
            s_next.pst = PW_RUN;
          else if (wc_edge)
            s_next.pcnt = s_reg.pcnt + 10'h001;
        end
        default: s_next.pst = s_reg.pst;
      endcase
    end

    // soft mute ramp, one step per frame; reversal keeps the position
    if (!trst)
      s_next.att = 13'h0000;
    else if (wc_edge && mute_req)
      s_next.att = (s_reg.att >= `DCM_RAMP_FULL - step) ? `DCM_RAMP_FULL
                   : s_reg.att + step;
    else if (wc_edge)
      s_next.att = (s_reg.att > step) ? s_reg.att - step : 13'h0000;

    for (int i = 0; i < 4; i++)
    begin
      if (s_reg.speed != SPD_NORMAL || (serial_on && !s_reg.regs[3][3 - i]))
        s_next.dem[2 * i +: 2] = `DCM_DEM_OFF;
      else
        s_next.dem[2 * i +: 2] = dem_rate;
    end
  end

  // ==================================================================
  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.regs <= {`DCM_RST_DEM, `DCM_RST_PWR, `DCM_RST_FSM, `DCM_RST_FMT};
      s_reg.per_meas <= 13'h1FFF;
      s_reg.dem <= 8'h55;
    end
    else
      s_reg <= s_next;
  end

  // ==================================================================
  // outputs; no read path exists on either port
  assign sda_o = 1'b0;
  assign sda_oe_n_o = !s_reg.sda_drv;
  assign serial_format_select_o = s_reg.regs[0][`DCM_LSB_FMT +: 3];
  assign multichannel_frame_select_o = s_reg.regs[0][`DCM_LSB_TDM +: 2];
  assign slow_rolloff_o = s_reg.regs[1][`DCM_BIT_SLOW];
  assign channel_power_bits_o = s_reg.regs[2][3:0];
  assign speed_o = s_reg.speed;
  assign deemph_mode_o = s_reg.dem;
  assign atten_level_o = s_reg.att;
  assign in_reset_o = s_reg.pst == PW_RESET;
  assign analog_up_o = s_reg.pst != PW_RESET && s_reg.pst != PW_ANALOG;
  assign digital_up_o = s_reg.pst == PW_PUMP || s_reg.pst == PW_RUN;
  assign output_valid_o = s_reg.pst == PW_RUN;

  // ==================================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence fast_two_s;
    (s_reg.speed != SPD_NORMAL) [*2];
  endsequence
  mute_down_a: assert property (wc_edge && mute_req && trst && s_reg.att < `DCM_RAMP_FULL
    |=> s_reg.att > $past(s_reg.att)) else $error("mute ramp stalled");
  unmute_up_a: assert property (wc_edge && !mute_req && trst && s_reg.att != 13'h0000
    |=> s_reg.att < $past(s_reg.att)) else $error("unmute ramp stalled");
  ramp_hold_a: assert property (!wc_edge && trst |=> $stable(s_reg.att))
    else $error("ramp moved without frame");
  dem_fast_a: assert property (fast_two_s |-> s_reg.dem == 8'h55)
    else $error("deemphasis on at high speed");
  clk_stop_a: assert property (mc_stop |=> s_reg.pst == PW_RESET)
    else $error("no reset on clock stop");
  stop_limit_a: assert property ($rose(wc_stop) |-> $past(s_reg.wc_idle) == `DCM_STOP_SAMPLES)
    else $error("frame stop declared early");
  early_write_a: assert property (!s_reg.wr_ok |=> $stable(s_reg.regs))
    else $error("write before hold time");
  read_nack_a: assert property (i2c_on && scl_fall && s_reg.ist == I_DEV && s_reg.ibit == 4'h8
    && s_reg.ish[0] |=> !s_reg.sda_drv) else $error("read address acknowledged");
  ptr_wrap_a: assert property (i2c_store && s_reg.ptr == `DCM_ADDR_LAST && !i2c_stop
    |=> s_reg.ptr == 5'h00) else $error("pointer did not wrap");
  valid_late_a: assert property ($rose(output_valid_o) |-> $past(s_reg.pst) == PW_PUMP)
    else $error("valid without pump count");
endmodule : dcm_ctrl
`default_nettype wire

// ===== logic/dcm_params.svh
/*
  offsets, field positions, reset values and timing counts of the dac control block.
  assumes a 50 MHz system clock; included by the package and the control module.
*/
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH
// ==================================================================
// register offsets
`define DCM_ADDR_FMT 5'h00
`define DCM_ADDR_FSM 5'h01
`define DCM_ADDR_PWR 5'h02
`define DCM_ADDR_DEM 5'h03
`define DCM_ADDR_LAST 5'h03
// ==================================================================
// reset values
`define DCM_RST_FMT 8'h89
`define DCM_RST_FSM 8'h02
`define DCM_RST_PWR 8'h0F
`define DCM_RST_DEM 8'h00
// ==================================================================
// field positions
`define DCM_BIT_TRST 0
`define DCM_LSB_FMT 2
`define DCM_LSB_TDM 5
`define DCM_BIT_AUTO_CLOCK_DETECT 7
`define DCM_BIT_MUTE 0
`define DCM_LSB_DEMR 1
`define DCM_LSB_DFS 3
`define DCM_BIT_SLOW 5
`define DCM_BIT_REGISTER_INIT_BIT 7
// ==================================================================
// protocol constants
`define DCM_3W_HEAD 3'h7
`define DCM_3W_BITS 5'h10
`define DCM_I2C_ADDR 6'h09
`define DCM_DEM_OFF 2'h1
// ==================================================================
// timing
`define DCM_CLK_PERIOD_NS 20
`define DCM_ANALOG_DELAY_NS 20000
`define DCM_ANALOG_CYC ((`DCM_ANALOG_DELAY_NS + `DCM_CLK_PERIOD_NS - 1) / `DCM_CLK_PERIOD_NS)
`define DCM_WRITE_HOLD_MS 10
`define DCM_WRITE_HOLD_CYC ((`DCM_WRITE_HOLD_MS * 1000000) / `DCM_CLK_PERIOD_NS)
`define DCM_RAMP_FULL 13'h1000
`define DCM_STOP_SAMPLES 12'h800
`define DCM_DIG_WAIT_LR 10'h009
`define DCM_CP_NORMAL 10'h040
`define DCM_CP_DOUBLE 10'h080
`define DCM_CP_QUAD 10'h100
`define DCM_MCLK_STOP_CYC 8'h40
`define DCM_NORMAL_MIN_PER 13'h02BC
`define DCM_DOUBLE_MIN_PER 13'h015E
`endif

// ===== logic/dcm_pkg.sv
/*
  types of the dac control block: speeds, state machines, register bank and full state.
  assumes dcm_params.svh is on the include path.
*/
`default_nettype none
`include "dcm_params.svh"
package dcm_pkg;
  typedef enum logic [1:0] {SPD_NORMAL, SPD_DOUBLE, SPD_QUAD} dcm_speed_t;
  typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG, I_DATA, I_SKIP} dcm_i2c_st_t;
  typedef enum logic [2:0] {PW_RESET, PW_ANALOG, PW_DIGITAL, PW_PUMP, PW_RUN} dcm_pw_st_t;
  typedef logic [3:0][7:0] dcm_regs_t;
  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] ck_s;
    logic [2:0] di_s;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] wc_s;
    logic [2:0] bc_s;
    logic [2:0] mc_s;
    logic [1:0] ser_s;
    logic [1:0] i2c_s;
    logic [1:0] sel_s;
    logic [2:0] par1;
    logic [2:0] par2;
    dcm_regs_t regs;
    logic [15:0] sh3;
    logic [4:0] n3;
    dcm_i2c_st_t ist;
    logic [3:0] ibit;
    logic [7:0] ish;
    logic iack;
    logic [4:0] ptr;
    logic sda_drv;
    logic [19:0] hold_cnt;
    logic wr_ok;
    logic [12:0] per_cnt;
    logic [12:0] per_meas;
    logic [12:0] tick_cnt;
    logic [11:0] wc_idle;
    logic [11:0] bc_idle;
    logic [7:0] mc_idle;
    dcm_speed_t speed;
    dcm_pw_st_t pst;
    logic [9:0] pcnt;
    logic [12:0] att;
    logic [7:0] dem;
  } dcm_state_t;
endpackage : dcm_pkg
`default_nettype wire

// ===== sim/dcm_host.sv
/*
  behavioural host for the dac control block: 3-wire and i2c write frames.
  assumes a free-running system clock and the wired-and sda level on sda_i.
*/
`default_nettype none
module dcm_host (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic chip_select_n_o,
  output logic control_serial_clock_o,
  output logic control_serial_in_o,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // idle levels
  initial
  begin
    chip_select_n_o = 1'b1;
    control_serial_clock_o = 1'b1;
    control_serial_in_o = 1'b0;
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // ==================================================================
  // 3-wire frame, 240 ns serial clock period
  task automatic w3(input logic [2:0] head, input logic [4:0] addr, input logic [7:0] data);
    logic [15:0] frame;
    frame = {head, addr, data};
    chip_select_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      tick(6);
      control_serial_clock_o <= 1'b0;
      control_serial_in_o <= frame[i];
      tick(6);
      control_serial_clock_o <= 1'b1;
    end
    tick(6);
    chip_select_n_o <= 1'b1;
    // released line must not keep the last bit
    control_serial_in_o <= ~frame[0];
    tick(8);
  endtask
  // ==================================================================
  // i2c master, data changes only while scl is low
  task automatic i2c_start();
    sda_o <= 1'b1;
    scl_o <= 1'b1;
    tick(6);
    sda_o <= 1'b0;
    tick(6);
    scl_o <= 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      tick(4);
      sda_o <= (i == 0) ? 1'b1 : b[i-1];
      tick(4);
      scl_o <= 1'b1;
      tick(5);
      ack = ~sda_i;
      tick(1);
      scl_o <= 1'b0;
    end
  endtask
  task automatic i2c_stop();
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b1;
    tick(6);
    sda_o <= 1'b1;
    tick(8);
  endtask
endmodule // dcm_host
`default_nettype wire

// ===== sim/tb_top.sv
/*
  self-checking bench of the dac control block with the host model.
  assumes dcm_pkg and dcm_ctrl are compiled first.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_i, serial_mode_i, i2c_mode_i, cad_i, par_mute_i;
  logic mc_run, wc_run, master_clock_i, word_clock_i, bit_clock_i;
  logic [1:0] par_dem_i;
  wire logic cs_n_w, control_serial_clock_w, control_serial_in_w, scl_w, sda_m_w, sda_o, sda_oe_n_o, slow_o;
  wire logic [2:0] fmt_o;
  wire logic [1:0] tdm_o, speed_o;
  wire logic [3:0] pwr_o, up_w;
  wire logic [7:0] dem_o;
  wire logic [12:0] att_o;
  wire logic sda_w = sda_m_w & (sda_oe_n_o | sda_o);
  int mismatches = 0;
  int num_checks = 0;
  // ==================================================================
  // clocks: bit clock 160 ns free, word clock 320 ns, master 80 ns
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    bit_clock_i = 1'b0;
    #3;
    forever #80 bit_clock_i = ~bit_clock_i;
  end
  initial
  begin
    master_clock_i = 1'b0;
    #7;
    forever #40 if (mc_run) master_clock_i = ~master_clock_i;
  end
  always @(posedge bit_clock_i) if (wc_run) word_clock_i <= ~word_clock_i;
  // ==================================================================
  // instances
  dcm_ctrl #(.WRITE_HOLD_CYC(10)) u_dcm_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .serial_mode_i(serial_mode_i), .i2c_mode_i(i2c_mode_i), .bus_address_select_pin_i(cad_i),
    .chip_select_n_i(cs_n_w), .control_serial_clock_i(control_serial_clock_w), .control_serial_in_i(control_serial_in_w),
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .master_clock_i(master_clock_i), .word_clock_i(word_clock_i), .bit_clock_i(bit_clock_i),
    .par_soft_silence_i(par_mute_i), .par_deemph_rate_select_i(par_dem_i),
    .serial_format_select_o(fmt_o), .multichannel_frame_select_o(tdm_o),
    .slow_rolloff_o(slow_o), .channel_power_bits_o(pwr_o), .speed_o(speed_o),
    .deemph_mode_o(dem_o), .atten_level_o(att_o), .in_reset_o(up_w[3]),
    .analog_up_o(up_w[0]), .digital_up_o(up_w[1]), .output_valid_o(up_w[2]));
  dcm_host u_dcm_host (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .chip_select_n_o(cs_n_w),
    .control_serial_clock_o(control_serial_clock_w), .control_serial_in_o(control_serial_in_w), .scl_o(scl_w),
    .sda_o(sda_m_w));
  // ==================================================================
  // shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_lvl(input int k, input logic lvl, input int lim, output int c);
    c = 0;
    while (up_w[k] !== lvl && c < lim)
    begin
      @(posedge clk_sys_i);
      c++;
    end
  endtask
  task automatic wait_att(input logic [12:0] t, output int n);
    n = 0;
    while (att_o !== t && n < 5000)
    begin
      @(posedge word_clock_i);
      n++;
    end
  endtask
  task automatic chk_defaults();
    check(16'({fmt_o, tdm_o, slow_o, pwr_o}), 16'h010F, "register defaults");
    check(16'({dem_o, 8'h00}), 16'h5500, "deemphasis default");
  endtask
  // ==================================================================
  // scenarios
  task automatic t_power();
    int c1, c2, c3;
    wait_lvl(0, 1'b1, 3000, c1);
    wait_lvl(1, 1'b1, 500, c2);
    wait_lvl(2, 1'b1, 6000, c3);
    check(16'(c1 >= 1000 && c1 <= 1300), 16'h0001, "analog delay");
    check(16'(c2 >= 124 && c2 <= 168), 16'h0001, "digital delay");
    check(16'(c3 >= 4076 && c3 <= 4120), 16'h0001, "valid delay");
    check(16'(speed_o), 16'h0002, "auto speed");
    $display("test power done");
  endtask
  task automatic t_wire3();
    u_dcm_host.w3(3'h7, 5'h02, 8'h00);
    check(16'(pwr_o), 16'h0000, "power off write");
    u_dcm_host.w3(3'h7, 5'h02, 8'h05);
    check(16'(pwr_o), 16'h0005, "frame commit");
    u_dcm_host.w3(3'h5, 5'h02, 8'h0F);
    check(16'(pwr_o), 16'h0005, "bad chip address");
    u_dcm_host.w3(3'h6, 5'h02, 8'h0F);
    check(16'(pwr_o), 16'h0005, "bad direction");
    u_dcm_host.w3(3'h7, 5'h00, 8'h09);
    for (int s = 0; s < 3; s++)
    begin
      u_dcm_host.w3(3'h7, 5'h01, {3'h1, 2'(s), 3'h2});
      check(16'({slow_o, speed_o}), 16'(4 + s), "manual speed");
    end
    $display("test wire3 done");
  endtask
  task automatic t_deemph();
    u_dcm_host.w3(3'h7, 5'h03, 8'h0A);
    for (int r = 0; r < 4; r++)
    begin
      u_dcm_host.w3(3'h7, 5'h01, {5'h00, 2'(r), 1'b0});
      check(16'(dem_o), 16'({2'h1, 2'(r), 2'h1, 2'(r)}), "rate per dac");
    end
    par_dem_i <= 2'h2;
    par_mute_i <= 1'b1;
    repeat (40) @(posedge clk_sys_i);
    check(16'(dem_o), 16'h0077, "pins ignored rate");
    check(16'(att_o), 16'h0000, "pins ignored mute");
    par_dem_i <= 2'h1;
    par_mute_i <= 1'b0;
    u_dcm_host.w3(3'h7, 5'h01, 8'h08);
    check(16'(dem_o), 16'h0055, "double speed off");
    $display("test deemph done");
  endtask
  task automatic t_i2c();
    logic a;
    i2c_mode_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    u_dcm_host.i2c_start();
    u_dcm_host.i2c_byte(8'h26, a);
    check(16'(a), 16'h0001, "address ack");
    u_dcm_host.i2c_byte(8'h02, a);
    check(16'(a), 16'h0001, "register ack");
    u_dcm_host.i2c_byte(8'h03, a);
    u_dcm_host.i2c_byte(8'h0C, a);
    u_dcm_host.i2c_byte(8'h11, a);
    check(16'(a), 16'h0001, "data ack");
    u_dcm_host.i2c_stop();
    check(16'({pwr_o, 1'b0, fmt_o}), 16'h0034, "pointer wrap");
    u_dcm_host.i2c_start();
    u_dcm_host.i2c_byte(8'h27, a);
    check(16'(a), 16'h0000, "read refused");
    u_dcm_host.i2c_stop();
    u_dcm_host.i2c_start();
    u_dcm_host.i2c_byte(8'h24, a);
    check(16'(a), 16'h0000, "other address");
    u_dcm_host.i2c_stop();
    i2c_mode_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    $display("test i2c done");
  endtask
  task automatic t_mute();
    int n, a;
    u_dcm_host.w3(3'h7, 5'h01, 8'h03);
    wait_att(13'h1000, n);
    check(16'(n >= 1022 && n <= 1028), 16'h0001, "mute ramp");
    u_dcm_host.w3(3'h7, 5'h01, 8'h02);
    wait_att(13'h0000, n);
    check(16'(n >= 1022 && n <= 1028), 16'h0001, "unmute ramp");
    u_dcm_host.w3(3'h7, 5'h01, 8'h03);
    repeat (200) @(posedge word_clock_i);
    u_dcm_host.w3(3'h7, 5'h01, 8'h02);
    a = int'(att_o);
    wait_att(13'h0000, n);
    check(16'(a > 780 && a < 1000), 16'h0001, "ramp stopped");
    check(16'(n * 4 >= a - 12 && n * 4 <= a + 12), 16'h0001, "early return");
    $display("test mute done");
  endtask
  task automatic t_trst();
    int c;
    u_dcm_host.w3(3'h7, 5'h00, 8'h10);
    check(16'({fmt_o, pwr_o, up_w[2]}), 16'h0086, "timing reset");
    u_dcm_host.w3(3'h7, 5'h00, 8'h11);
    wait_lvl(2, 1'b1, 3000, c);
    check(16'(up_w[2]), 16'h0001, "timing restart");
    $display("test trst done");
  endtask
  task automatic t_clkstop();
    int c;
    wc_run <= 1'b0;
    wait_lvl(3, 1'b1, 34000, c);
    check(16'(c >= 32700 && c <= 32900), 16'h0001, "word stop time");
    wc_run <= 1'b1;
    wait_lvl(3, 1'b0, 1500, c);
    check(16'(up_w[3]), 16'h0000, "word restart");
    mc_run <= 1'b0;
    wait_lvl(3, 1'b1, 200, c);
    check(16'({c >= 58 && c <= 72, up_w[2]}), 16'h0002, "master stop");
    mc_run <= 1'b1;
    wait_lvl(3, 1'b0, 1500, c);
    check(16'(up_w[3]), 16'h0000, "master restart");
    $display("test clkstop done");
  endtask
  // ==================================================================
  // sequence, watchdog and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    summarize();
  end
  initial
  begin
    rst_i = 1'b1;
    serial_mode_i = 1'b1;
    i2c_mode_i = 1'b0;
    cad_i = 1'b1;
    par_mute_i = 1'b0;
    par_dem_i = 2'h1;
    mc_run = 1'b1;
    wc_run = 1'b1;
    word_clock_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // power-up wait keeps the first write far past the hold time
    t_power();
    chk_defaults();
    t_wire3();
    t_deemph();
    t_i2c();
    t_mute();
    t_trst();
    t_clkstop();
    u_dcm_host.w3(3'h7, 5'h01, 8'h80);
    chk_defaults();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
